// ### bench/data_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module data_mem_model (
	// System
	input  wire logic        clock,
	// Memory port
	input  wire logic [11:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	// ----------------------------------------
	// Data memory
	// ----------------------------------------
	logic [7:0] mem [4096];
	logic [7:0] held;
	logic       shown;
	initial begin
		held = 8'h00;
		shown = 1'b0;
	end
	// Valid in the strobe cycle and the next, inverted garbage otherwise
	assign mem_rdata = mem_rd ? mem[mem_addr] : (shown ? held : ~held);
	always @(posedge clock) begin
		shown <= mem_rd;
		if (mem_rd)
			held <= mem[mem_addr];
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
	end
endmodule
`default_nettype wire

// ### bench/data_move_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
module data_move_exec_tb;
	logic        clock;
	logic        sys_rst;
	logic [15:0] instr_word;
	logic        ext_enable;
	logic [11:0] mem_addr;
	logic        mem_rd;
	logic        mem_wr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic [7:0]  acc;
	logic        flag_neg;
	logic        flag_zero;
	logic [11:0] ptr0;
	logic [11:0] ptr1;
	logic [11:0] ptr2;
	logic [3:0]  bank_select;
	logic        second_word;
	logic        illegal_dest;
	int          n_fail;
	int          n_checks;
	logic [11:0] ptr_k [3] = '{12'h1AB, 12'h2CD, 12'h300};
	logic [9:0]  st_op [8] = '{10'h010, 10'h060, 10'h17F, 10'h05F, 10'h25F, 10'h260, 10'h320, 10'h1FF};
	logic [11:0] st_adr [8] = '{12'h010, 12'hF60, 12'h07F, 12'h05F, 12'h35F, 12'hF60, 12'h020, 12'h0FF};
	logic [11:0] bad [4] = '{12'hFF9, 12'hFFD, 12'hFFE, 12'hFFF};

	data_move_exec data_move_exec_i (
		.clock(clock), .sys_rst(sys_rst), .instr_word(instr_word), .ext_enable(ext_enable),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .acc(acc), .flag_neg(flag_neg), .flag_zero(flag_zero),
		.ptr0(ptr0), .ptr1(ptr1), .ptr2(ptr2), .bank_select(bank_select),
		.second_word(second_word), .illegal_dest(illegal_dest)
	);
	data_mem_model data_mem_model_i (
		.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
	);

	// ----------------------------------------
	// Clock, instruction issue and compare
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic issue(input logic [15:0] w);
		instr_word <= w;
		repeat (4) @(posedge clock);
	endtask
	task automatic move(input logic [11:0] s, input logic [11:0] d);
		issue({4'hC, s});
		issue({4'hF, d});
		issue(16'h0000);
	endtask
	task automatic results;
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		n_fail = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		instr_word = 16'h0000;
		ext_enable = 1'b0;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		check(bank_select, 4'h0, "bank reset");
		for (int i = 0; i < 3; i++) begin
			issue({8'hEE, 2'b00, i[1:0], ptr_k[i][11:8]});
			issue({8'hF0, ptr_k[i][7:0]});
			check(second_word, 1'b1, "second word pending");
		end
		issue(16'h0000);
		check(ptr0, ptr_k[0], "ptr0");
		check(ptr1, ptr_k[1], "ptr1");
		check(ptr2, ptr_k[2], "ptr2");
		$display("Test pointer load done");
		data_mem_model_i.mem[12'h020] = 8'h80;
		data_mem_model_i.mem[12'h022] = 8'h7F;
		data_mem_model_i.mem[12'h021] = 8'h00;
		issue(16'h5020);
		issue(16'h0000);
		check(acc, 8'h80, "copy to acc");
		check(flag_neg, 1'b1, "neg flag");
		issue(16'h5322);
		issue(16'h0000);
		check(acc, 8'h80, "acc kept");
		check(data_mem_model_i.mem[12'h022], 8'h7F, "copy back");
		check(flag_neg, 1'b0, "neg clear");
		data_mem_model_i.mem[12'h302] = 8'hC3;
		ext_enable <= 1'b1;
		issue(16'h5002);
		ext_enable <= 1'b0;
		issue(16'h0000);
		check(acc, 8'hC3, "indexed copy");
		check(flag_neg, 1'b1, "neg after indexed copy");
		issue(16'h5021);
		issue(16'h0000);
		check(flag_zero, 1'b1, "zero flag");
		issue(16'h0E5A);
		issue(16'h0000);
		check(acc, 8'h5A, "literal");
		check(flag_zero, 1'b1, "flags after literal");
		$display("Test copy and literal done");
		for (int i = 0; i < 8; i++) begin
			ext_enable <= st_op[i][9];
			data_mem_model_i.mem[st_adr[i]] = 8'h00;
			issue({7'h37, st_op[i][8:0]});
			issue(16'h0000);
			check(data_mem_model_i.mem[st_adr[i]], 8'h5A, "store");
		end
		ext_enable <= 1'b0;
		check(flag_zero, 1'b1, "flags after store");
		$display("Test store addressing done");
		data_mem_model_i.mem[12'hA23] = 8'h33;
		data_mem_model_i.mem[12'hB56] = 8'h11;
		move(12'hA23, 12'hB56);
		check(data_mem_model_i.mem[12'hB56], 8'h33, "reg move");
		check(flag_zero, 1'b1, "flags after move");
		move(12'hA23, 12'hFE8);
		check(acc, 8'h33, "move to acc");
		issue(16'h0EC4);
		data_mem_model_i.mem[12'hFE8] = 8'hEE;
		move(12'hFE8, 12'h457);
		check(data_mem_model_i.mem[12'h457], 8'hC4, "move from acc");
		check(illegal_dest, 1'b0, "no fault yet");
		$display("Test register move done");
		for (int i = 0; i < 4; i++) begin
			data_mem_model_i.mem[bad[i]] = 8'h99;
			move(12'hA23, bad[i]);
			check(data_mem_model_i.mem[bad[i]], 8'h99, "forbidden dest");
		end
		check(illegal_dest, 1'b1, "fault flag");
		$display("Test forbidden destination done");
		results();
	end
endmodule
`default_nettype wire

// ### common/data_move_params.svh
`ifndef DATA_MOVE_PARAMS_SVH
`define DATA_MOVE_PARAMS_SVH
// Opcode prefixes in the upper bits of the first or second word
`define OPC_LOAD_PTR        8'hEE
`define OPC_LOAD_PTR_HI     4'h0
`define OPC_SECOND_WORD     4'hF
`define OPC_COPY_FILE       6'h14
`define OPC_LOAD_LIT        8'h0E
`define OPC_STORE_ACC       7'h37
`define OPC_COPY_R2R        4'hC
// Addressing
`define INDEXED_LIMIT       8'h5F
`define ACCESS_SPLIT        8'h60
`define ACCESS_HIGH_PAGE    4'hF
// Special addresses in the data space
`define ADDR_ACC            12'hFE8
`define ADDR_PCL            12'hFF9
`define ADDR_STACK_TOP_BYTE0           12'hFFD
`define ADDR_STACK_TOP_HIGH           12'hFFE
`define ADDR_STACK_TOP_UPPER           12'hFFF
`define ADDR_PTR0_LOW       12'hFE9
`define ADDR_PTR1_LOW       12'hFE1
`define ADDR_PTR2_LOW       12'hFD9
// Reset values
`define RST_ACC             8'h00
`define RST_BANK            4'h0
`define RST_PTR             12'h000
`endif

// ### common/data_move_pkg.sv
package data_move_pkg;
	typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
	typedef enum logic [2:0] {OP_NONE, OP_LOAD_PTR, OP_COPY_FILE, OP_LOAD_LIT, OP_STORE_ACC, OP_COPY_R2R} op_t;
endpackage

// ### verilog/addr_resolve.sv
`timescale 1ns/10ps
`default_nettype none
`include "data_move_params.svh"
module addr_resolve
	import data_move_pkg::*;
(
	// Operand
	input  wire logic [7:0]  file_field,
	input  wire logic        access_sel,
	// Context
	input  wire logic [3:0]  bank_select,
	input  wire logic        ext_enable,
	input  wire logic [11:0] index_base,
	// Result
	output logic      [11:0] full_addr
);
	logic [11:0] index_sum;

	assign index_sum = index_base + {4'h0, file_field};

	always_comb begin
		if (access_sel)
			full_addr = {bank_select, file_field};
		else if (ext_enable && (file_field <= `INDEXED_LIMIT))
			full_addr = index_sum;
		else if (file_field < `ACCESS_SPLIT)
			full_addr = {4'h0, file_field};
		else
			full_addr = {`ACCESS_HIGH_PAGE, file_field};
	end
endmodule
`default_nettype wire

// ### verilog/data_move_exec.sv
// What this block does
// - Load pointer: 12-bit literal, two words, high first
// - Copy register to destination, set negative/zero flags
// - Destination bit 0 accumulator, 1 register
// - Access bit selects access bank or bank select
// - Extended set, access 0, f<=95: indexed offset
// - Eight-bit operand reaches whole 256-byte bank
// - Reg-to-reg move: 12-bit source and destination words
// - Reg-to-reg: two cycles, flags kept, write last phase
// - Accumulator may be source or destination
// - Load literal into accumulator, flags kept
// - Store accumulator to register, flags kept
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "data_move_params.svh"
module data_move_exec
	import data_move_pkg::*;
(
	// System
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Instruction stream, one word per instruction cycle
	input  wire logic [15:0] instr_word,
	input  wire logic        ext_enable,
	// Data memory
	output logic      [11:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [7:0]  mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	// Core state
	output logic      [7:0]  acc,
	output logic             flag_neg,
	output logic             flag_zero,
	output logic      [11:0] ptr0,
	output logic      [11:0] ptr1,
	output logic      [11:0] ptr2,
	output logic      [3:0]  bank_select,
	output logic             second_word,
	output logic             illegal_dest
);
	phase_t      phase;
	op_t         op;
	logic [15:0] ir;
	logic [7:0]  hold;
	logic [11:0] res_addr;
	logic [1:0]  ptr_sel;
	logic [3:0]  ptr_hi;

	op_t         next_op;
	logic [15:0] next_ir;
	logic [7:0]  next_hold;
	logic [7:0]  next_acc;
	logic        next_neg;
	logic        next_zero;
	logic [11:0] next_ptr0;
	logic [11:0] next_ptr1;
	logic [11:0] next_ptr2;
	logic [1:0]  next_ptr_sel;
	logic [3:0]  next_ptr_hi;
	logic        next_second;
	logic        next_illegal;
	logic [11:0] next_mem_addr;
	logic        next_mem_rd;
	logic        next_mem_wr;
	logic [7:0]  next_mem_wdata;

	// ---------------------------------------------------------------
	// Phase sequencer and address resolution
	// ---------------------------------------------------------------
	phase_gen u_phase (
		.clock   (clock),
		.sys_rst (sys_rst),
		.phase   (phase)
	);

	addr_resolve u_addr (
		.file_field  (ir[7:0]),
		.access_sel  (ir[8]),
		.bank_select (bank_select),
		.ext_enable  (ext_enable),
		.index_base  (ptr2),
		.full_addr   (res_addr)
	);

	// ---------------------------------------------------------------
	// Execution
	// ---------------------------------------------------------------
	always_comb begin
		next_op        = op;
		next_ir        = ir;
		next_hold      = hold;
		next_acc       = acc;
		next_neg       = flag_neg;
		next_zero      = flag_zero;
		next_ptr0      = ptr0;
		next_ptr1      = ptr1;
		next_ptr2      = ptr2;
		next_ptr_sel   = ptr_sel;
		next_ptr_hi    = ptr_hi;
		next_second    = second_word;
		next_illegal   = illegal_dest;
		next_mem_addr  = mem_addr;
		next_mem_rd    = 1'b0;
		next_mem_wr    = 1'b0;
		next_mem_wdata = mem_wdata;
		case (phase)
			PH_DECODE: begin
				next_ir = instr_word;
				if (second_word) begin
					next_op = op;
				end else if (instr_word[15:8] == `OPC_LOAD_PTR && instr_word[7:6] == 2'b00) begin
					next_op = OP_LOAD_PTR;
				end else if (instr_word[15:10] == `OPC_COPY_FILE) begin
					next_op = OP_COPY_FILE;
				end else if (instr_word[15:8] == `OPC_LOAD_LIT) begin
					next_op = OP_LOAD_LIT;
				end else if (instr_word[15:9] == `OPC_STORE_ACC) begin
					next_op = OP_STORE_ACC;
				end else if (instr_word[15:12] == `OPC_COPY_R2R) begin
					next_op = OP_COPY_R2R;
				end else begin
					next_op = OP_NONE;
				end
			end
			PH_READ: begin
				case (op)
					OP_COPY_FILE: begin
						next_mem_addr = res_addr;
						next_mem_rd   = 1'b1;
					end
					OP_COPY_R2R: begin
						if (!second_word && ir[11:0] != `ADDR_ACC) begin
							next_mem_addr = ir[11:0];
							next_mem_rd   = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
			PH_PROCESS: begin
				case (op)
					OP_COPY_FILE: begin
						next_hold = mem_rdata;
					end
					OP_COPY_R2R: begin
						if (!second_word)
							next_hold = (ir[11:0] == `ADDR_ACC) ? acc : mem_rdata;
					end
					OP_LOAD_PTR: begin
						if (!second_word) begin
							next_ptr_sel = ir[5:4];
							next_ptr_hi  = ir[3:0];
						end
					end
					default: begin
					end
				endcase
			end
			PH_WRITE: begin
				case (op)
					OP_LOAD_PTR: begin
						if (!second_word) begin
							next_second = 1'b1;
							case (ptr_sel)
								2'd0:    next_ptr0[11:8] = ptr_hi;
								2'd1:    next_ptr1[11:8] = ptr_hi;
								2'd2:    next_ptr2[11:8] = ptr_hi;
								default: next_illegal = 1'b1;
							endcase
						end else begin
							next_second = 1'b0;
							case (ptr_sel)
								2'd0:    next_ptr0[7:0] = ir[7:0];
								2'd1:    next_ptr1[7:0] = ir[7:0];
								2'd2:    next_ptr2[7:0] = ir[7:0];
								default: next_illegal = 1'b1;
							endcase
							next_op = OP_NONE;
						end
					end
					OP_COPY_FILE: begin
						next_neg  = hold[7];
						next_zero = (hold == 8'h00);
						if (!ir[9]) begin
							next_acc = hold;
						end else begin
							next_mem_addr  = res_addr;
							next_mem_wdata = hold;
							next_mem_wr    = 1'b1;
						end
					end
					OP_LOAD_LIT: begin
						next_acc = ir[7:0];
					end
					OP_STORE_ACC: begin
						next_mem_addr  = res_addr;
						next_mem_wdata = acc;
						next_mem_wr    = 1'b1;
					end
					OP_COPY_R2R: begin
						if (!second_word) begin
							next_second = 1'b1;
						end else begin
							next_second = 1'b0;
							next_op     = OP_NONE;
							if (ir[15:12] != `OPC_SECOND_WORD ||
							    ir[11:0] == `ADDR_PCL || ir[11:0] == `ADDR_STACK_TOP_BYTE0 ||
							    ir[11:0] == `ADDR_STACK_TOP_HIGH || ir[11:0] == `ADDR_STACK_TOP_UPPER) begin
								next_illegal = 1'b1;
							end else if (ir[11:0] == `ADDR_ACC) begin
								next_acc = hold;
							end else begin
								next_mem_addr  = ir[11:0];
								next_mem_wdata = hold;
								next_mem_wr    = 1'b1;
							end
						end
					end
					default: begin
					end
				endcase
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			op           <= OP_NONE;
			ir           <= 16'h0000;
			hold         <= 8'h00;
			acc          <= `RST_ACC;
			flag_neg     <= 1'b0;
			flag_zero    <= 1'b0;
			ptr0         <= `RST_PTR;
			ptr1         <= `RST_PTR;
			ptr2         <= `RST_PTR;
			ptr_sel      <= 2'd0;
			ptr_hi       <= 4'h0;
			bank_select  <= `RST_BANK;
			second_word  <= 1'b0;
			illegal_dest <= 1'b0;
			mem_addr     <= 12'h000;
			mem_rd       <= 1'b0;
			mem_wr       <= 1'b0;
			mem_wdata    <= 8'h00;
		end else begin
			op           <= next_op;
			ir           <= next_ir;
			hold         <= next_hold;
			acc          <= next_acc;
			flag_neg     <= next_neg;
			flag_zero    <= next_zero;
			ptr0         <= next_ptr0;
			ptr1         <= next_ptr1;
			ptr2         <= next_ptr2;
			ptr_sel      <= next_ptr_sel;
			ptr_hi       <= next_ptr_hi;
			bank_select  <= bank_select;
			second_word  <= next_second;
			illegal_dest <= next_illegal;
			mem_addr     <= next_mem_addr;
			mem_rd       <= next_mem_rd;
			mem_wr       <= next_mem_wr;
			mem_wdata    <= next_mem_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	phases_cycle_a: assert property (@(posedge clock) disable iff (sys_rst)
		phase == PH_DECODE |=> phase == PH_READ ##1 phase == PH_PROCESS ##1 phase == PH_WRITE)
		else $error("phase order broken");
	copy_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
		(phase == PH_WRITE && op == OP_COPY_FILE) |=> (flag_zero == (hold == 8'h00)) && (flag_neg == hold[7]))
		else $error("copy flags wrong");
	dest_acc_a: assert property (@(posedge clock) disable iff (sys_rst)
		(phase == PH_WRITE && op == OP_COPY_FILE && !ir[9]) |=> acc == $past(hold) && !mem_wr)
		else $error("copy to accumulator failed");
	dest_reg_a: assert property (@(posedge clock) disable iff (sys_rst)
		(phase == PH_WRITE && op == OP_COPY_FILE && ir[9]) |=> mem_wr && mem_wdata == $past(hold))
		else $error("copy write back failed");
	literal_load_a: assert property (@(posedge clock) disable iff (sys_rst)
		(phase == PH_WRITE && op == OP_LOAD_LIT) |=> acc == $past(ir[7:0]) && $stable(flag_zero))
		else $error("literal load failed");
	store_acc_a: assert property (@(posedge clock) disable iff (sys_rst)
		(phase == PH_WRITE && op == OP_STORE_ACC) |=> mem_wr && mem_wdata == acc && mem_addr == $past(res_addr))
		else $error("store accumulator failed");
	r2r_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
		(phase == PH_WRITE && op == OP_COPY_R2R) |=> $stable(flag_neg) && $stable(flag_zero))
		else $error("register move altered flags");
	r2r_two_cycles_a: assert property (@(posedge clock) disable iff (sys_rst)
		(phase == PH_WRITE && op == OP_COPY_R2R && !second_word) |=> second_word ##4 !second_word)
		else $error("register move length wrong");
	ptr_two_words_a: assert property (@(posedge clock) disable iff (sys_rst)
		(phase == PH_WRITE && op == OP_LOAD_PTR && !second_word) |=> second_word ##4 !second_word)
		else $error("pointer load length wrong");
	bank_addr_a: assert property (@(posedge clock) disable iff (sys_rst)
		(ir[8] && phase == PH_READ && op == OP_COPY_FILE) |=> mem_addr == {bank_select, ir[7:0]})
		else $error("banked address wrong");
	indexed_addr_a: assert property (@(posedge clock) disable iff (sys_rst)
		(!ir[8] && ext_enable && ir[7:0] <= `INDEXED_LIMIT && phase == PH_READ && op == OP_COPY_FILE)
		|=> mem_addr == ptr2 + {4'h0, ir[7:0]})
		else $error("indexed address wrong");
endmodule
`default_nettype wire

// ### verilog/phase_gen.sv
`timescale 1ns/10ps
`default_nettype none
module phase_gen
	import data_move_pkg::*;
(
	// System
	input  wire logic clock,
	input  wire logic sys_rst,
	// Phase
	output phase_t    phase
);
	phase_t next_phase;

	always_comb begin
		case (phase)
			PH_DECODE:  next_phase = PH_READ;
			PH_READ:    next_phase = PH_PROCESS;
			PH_PROCESS: next_phase = PH_WRITE;
			PH_WRITE:   next_phase = PH_DECODE;
			default:    next_phase = PH_DECODE;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			phase <= PH_DECODE;
		else
			phase <= next_phase;
	end
endmodule
`default_nettype wire
